// ### rtl/tss_pkg.sv
// Constants for the trigger and sweep sequencer: register map, field
// positions, reset values and the mode, source and command encodings.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none
package tss_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CMD    = 8'h04;
   localparam logic [7:0] OFS_DISP   = 8'h08;
   localparam logic [7:0] OFS_MODE   = 8'h0C;
   localparam logic [7:0] OFS_PORTS  = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // ==========================================================
   // Field positions
   localparam int CMD_BUS_TRG  = 0;  // Remote trigger command
   localparam int CMD_RESTART  = 1;  // Abort the running sweep
   localparam int CMD_HOLD_ALL = 2;  // Every channel to hold
   localparam int CMD_CONT_DSP = 3;  // Displayed channels to continuous
   localparam int PORTS_CAL_LSB = 4; // Calibrated port mask
   localparam int ST_BUSY      = 0;
   localparam int ST_CHAN_LSB  = 4;
   localparam int ST_PORT_LSB  = 8;
   localparam int ST_INIT_LSB  = 16;
   // ==========================================================
   // Reset values
   localparam logic [31:0] RST_DISP  = 32'h0000_0001;
   localparam logic [31:0] RST_MODE  = 32'h0000_0000;
   localparam logic [3:0]  RST_NEED  = 4'h3;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;
   // ==========================================================
   // Encodings
   typedef enum logic [1:0] {
      SRC_INT, SRC_EXT, SRC_MAN, SRC_BUS
   } tss_src_t;
   localparam logic [1:0] MODE_HOLD   = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_CONT   = 2'h2;
endpackage : tss_pkg
`default_nettype wire

// ### rtl/tss_trigger_sweep.sv
// Trigger and sweep sequencer: trigger source selection, per-channel
// trigger modes and the channel/port sweep order, behind AXI4-Lite.
// Assumes all inputs synchronous to sys_clk; the measurement engine
// answers each meas_req_q with a one-cycle meas_done.
// How it works
// RULE1 - One source; sweep initiated channels ascending
// RULE2 - Sweep decision ignores display state
// RULE3 - Skip stimulus ports no trace needs
// RULE4 - Stimulus ports one at a time ascending
// RULE5 - Calibrated traces refresh after last calibrated port
// RULE6 - Four sources, exactly one selected
// RULE7 - Internal source retriggers after each sweep
// RULE8 - Internal source starts triggering at once
// RULE9 - External source uses the trigger input
// RULE10 - Manual source triggers per key press
// RULE11 - Bus source triggers per remote command
// RULE12 - Each channel has its own mode
// RULE13 - Hold channel is idle, never swept
// RULE14 - Single sweeps once then goes idle
// RULE15 - Continuous stays initiated after sweep
// RULE16 - Group command sets all channels hold
// RULE17 - Group command: displayed channels continuous
// RULE18 - Restart aborts a running sweep at once
// RULE19 - Triggers ignored while a sweep runs
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`default_nettype none
module tss_trigger_sweep #(
   parameter int NCH   = 16,
   parameter int NPORT = 4
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        ext_trig,
   input  wire logic        trig_key,
   input  wire logic        meas_done,
   output var  logic        meas_req_q,
   output var  logic [3:0]  meas_chan_q,
   output var  logic [1:0]  meas_port_q,
   output var  logic [3:0]  upd_q,
   output var  logic        trig_q,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // Elaboration check: status fields hold 16 channels and 4 ports
   if (NCH < 1 || NCH > 16 || NPORT < 1 || NPORT > 4)
   begin : g_param_chk
      $error("tss_trigger_sweep: NCH 1..16, NPORT 1..4");
   end

   // ==========================================================
   // Functions
   // Lowest set bit at or above start; bit 5 flags a hit
   function automatic logic [5:0] find_next(input logic [31:0] v,
                                            input logic [4:0] start);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 31; i >= 0; i--)
      begin
         if (v[i] && i >= int'(start))
            r = {1'b1, 5'(i)};
      end
      return r;
   endfunction : find_next

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction : merge

   // ==========================================================
   // Bus write side
   logic       aw_got_q, w_got_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic       wr_fire;
   assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

   // Address and data taken in either order, response after both
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= tss_pkg::RESP_OK;
      end
      else
      begin
         s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_got_q
                          && !s_axi_bvalid;
         s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_got_q
                          && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q <= tss_pkg::OFS_STATUS &&
                             awaddr_q[1:0] == 2'h0) ?
                            tss_pkg::RESP_OK : tss_pkg::RESP_ERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Configuration registers
   tss_pkg::tss_src_t src_q;
   logic [NCH-1:0]    disp_q;
   logic [2*NCH-1:0]  mode_q;
   logic [NPORT-1:0]  need_q, cal_q;
   logic wr_ctrl, wr_mode, wr_cmd, wr_ports, wr_disp;
   logic bus_trg, restart, hold_all, cont_dsp;
   logic [31:0] mode_m;
   assign wr_ctrl  = wr_fire && awaddr_q == tss_pkg::OFS_CTRL;
   assign wr_cmd   = wr_fire && awaddr_q == tss_pkg::OFS_CMD && wstrb_q[0];
   assign wr_disp  = wr_fire && awaddr_q == tss_pkg::OFS_DISP;
   assign wr_mode  = wr_fire && awaddr_q == tss_pkg::OFS_MODE;
   assign wr_ports = wr_fire && awaddr_q == tss_pkg::OFS_PORTS;
   assign bus_trg  = wr_cmd && wdata_q[tss_pkg::CMD_BUS_TRG];
   assign restart  = wr_cmd && wdata_q[tss_pkg::CMD_RESTART];
   assign hold_all = wr_cmd && wdata_q[tss_pkg::CMD_HOLD_ALL];
   assign cont_dsp = wr_cmd && wdata_q[tss_pkg::CMD_CONT_DSP];
   assign mode_m   = merge(32'(mode_q), wdata_q, wstrb_q);

   // One source register, so exactly one source is in effect
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         src_q  <= tss_pkg::SRC_INT;
         disp_q <= NCH'(tss_pkg::RST_DISP);
         need_q <= NPORT'(tss_pkg::RST_NEED);
         cal_q  <= '0;
      end
      else
      begin
         if (wr_ctrl && wstrb_q[0])
            src_q <= tss_pkg::tss_src_t'(wdata_q[1:0]); // see RULE6
         if (wr_disp)
            disp_q <= NCH'(merge(32'(disp_q), wdata_q, wstrb_q));
         if (wr_ports && wstrb_q[0])
         begin
            need_q <= wdata_q[NPORT-1:0];
            cal_q  <= wdata_q[tss_pkg::PORTS_CAL_LSB +: NPORT];
         end
      end
   end

   // ==========================================================
   // Sweep sequencer
   typedef enum logic [1:0] {S_IDLE, S_CHAN, S_PORT, S_MEAS} tss_st_t;
   tss_st_t    st_q;
   logic [4:0] ch_q;
   logic [2:0] port_q;
   logic [NCH-1:0] init_v;
   logic ext_prev_q, key_prev_q, ext_rise, key_rise, trig_d;
   logic [5:0] ch_hit, port_hit;
   logic ch_done;
   logic [3:0] upd_d;

   // Initiate state comes from the mode alone, never from the display
   always_comb
   begin
      for (int c = 0; c < NCH; c++)
         init_v[c] = mode_q[2*c +: 2] != tss_pkg::MODE_HOLD; // see RULE2
   end

   assign ext_rise = ext_trig && !ext_prev_q;
   assign key_rise = trig_key && !key_prev_q;
   assign ch_hit   = find_next(32'(init_v), ch_q);            // see RULE1
   assign port_hit = find_next(32'(need_q), 5'(port_q));      // see RULE3
   assign ch_done  = st_q == S_PORT && !port_hit[5];

   // Only an idle sequencer accepts the selected source
   always_comb
   begin
      trig_d = 1'b0;
      if (st_q == S_IDLE && !restart)                         // see RULE19
      begin
         unique case (src_q)
            tss_pkg::SRC_INT: trig_d = 1'b1;           // see RULE7 RULE8
            tss_pkg::SRC_EXT: trig_d = ext_rise;              // see RULE9
            tss_pkg::SRC_MAN: trig_d = key_rise;              // see RULE10
            tss_pkg::SRC_BUS: trig_d = bus_trg;               // see RULE11
         endcase
      end
   end

   // Refresh mask: calibrated ports wait for the last of them
   always_comb
   begin
      upd_d = 4'(1 << meas_port_q);                           // see RULE4
      if (cal_q[meas_port_q])
      begin
         // Three-bit shift count: the last port must not wrap to zero
         if ((4'(cal_q) >> ({1'b0, meas_port_q} + 3'h1)) == 4'h0) // see RULE5
            upd_d = 4'(cal_q);
         else
            upd_d = 4'h0;
      end
   end

   // Input edge history
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ext_prev_q <= 1'b0;
         key_prev_q <= 1'b0;
      end
      else
      begin
         ext_prev_q <= ext_trig;
         key_prev_q <= trig_key;
      end
   end

   // Channel then port walk; restart wins over everything
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_q        <= S_IDLE;
         ch_q        <= 5'h00;
         port_q      <= 3'h0;
         meas_req_q  <= 1'b0;
         meas_chan_q <= 4'h0;
         meas_port_q <= 2'h0;
         upd_q       <= 4'h0;
         trig_q      <= 1'b0;
      end
      else
      begin
         trig_q <= trig_d;
         upd_q  <= 4'h0;
         if (restart)
         begin
            st_q       <= S_IDLE;                            // see RULE18
            meas_req_q <= 1'b0;
         end
         else
         begin
            unique case (st_q)
               S_IDLE:
                  if (trig_d)
                  begin
                     st_q <= S_CHAN;
                     ch_q <= 5'h00;
                  end
               S_CHAN:
                  if (ch_hit[5] && int'(ch_hit[4:0]) < NCH)  // see RULE13
                  begin
                     ch_q   <= ch_hit[4:0];
                     port_q <= 3'h0;
                     st_q   <= S_PORT;
                  end
                  else
                     st_q <= S_IDLE;
               S_PORT:
                  if (port_hit[5] && int'(port_hit[4:0]) < NPORT)
                  begin
                     meas_req_q  <= 1'b1;
                     meas_chan_q <= ch_q[3:0];
                     meas_port_q <= port_hit[1:0];
                     st_q        <= S_MEAS;
                  end
                  else
                  begin
                     ch_q <= ch_q + 5'h01;                   // see RULE1
                     st_q <= (int'(ch_q) == NCH - 1) ? S_IDLE : S_CHAN;
                  end
               S_MEAS:
                  if (meas_done)
                  begin
                     meas_req_q <= 1'b0;
                     upd_q      <= upd_d;
                     port_q     <= {1'b0, meas_port_q} + 3'h1;  // see RULE4
                     st_q       <= S_PORT;
                  end
            endcase
         end
      end
   end

   // Trigger modes; a software write beats the automatic return to idle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         mode_q <= (2*NCH)'(tss_pkg::RST_MODE);
      else if (wr_mode)
         mode_q <= mode_m[2*NCH-1:0];                        // see RULE12
      else if (hold_all)
         mode_q <= '0;                                       // see RULE16
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            if (cont_dsp && disp_q[c])
               mode_q[2*c +: 2] <= tss_pkg::MODE_CONT;       // see RULE17
            else if (ch_done && !restart && int'(ch_q) == c &&
                     mode_q[2*c +: 2] == tss_pkg::MODE_SINGLE)  // see RULE15
               mode_q[2*c +: 2] <= tss_pkg::MODE_HOLD;       // see RULE14
         end
      end
   end

   // ==========================================================
   // Bus read side
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= tss_pkg::RESP_OK;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tss_pkg::RESP_OK;
            s_axi_rdata  <= 32'h0000_0000;
            unique case (s_axi_araddr)
               tss_pkg::OFS_CTRL:  s_axi_rdata <= 32'(src_q);
               tss_pkg::OFS_CMD:   s_axi_rdata <= 32'h0000_0000;
               tss_pkg::OFS_DISP:  s_axi_rdata <= 32'(disp_q);
               tss_pkg::OFS_MODE:  s_axi_rdata <= 32'(mode_q);
               tss_pkg::OFS_PORTS:
                  s_axi_rdata <= 32'({cal_q, 4'(need_q)});
               tss_pkg::OFS_STATUS:
               begin
                  s_axi_rdata[tss_pkg::ST_BUSY] <= st_q != S_IDLE;
                  s_axi_rdata[tss_pkg::ST_CHAN_LSB +: 4] <= meas_chan_q;
                  s_axi_rdata[tss_pkg::ST_PORT_LSB +: 2] <= meas_port_q;
                  s_axi_rdata[tss_pkg::ST_INIT_LSB +: NCH] <= init_v;
               end
               default: s_axi_rresp <= tss_pkg::RESP_ERR;
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic go;
   logic [3:0] last_ch_q;
   logic [1:0] last_pt_q;
   logic       seen_q;
   assign go = st_q == S_PORT && port_hit[5] && int'(port_hit[4:0]) < NPORT
               && !restart;
   // History of the previous measurement in this sequence
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || trig_d)
         seen_q <= 1'b0;
      else if (go)
      begin
         seen_q    <= 1'b1;
         last_ch_q <= ch_q[3:0];
         last_pt_q <= port_hit[1:0];
      end
   end

   chan_order_a: assert property (go && seen_q |-> ch_q[3:0] >= last_ch_q)
      else $error("channel order broken"); // see RULE1
   port_order_a: assert property (go && seen_q && ch_q[3:0] == last_ch_q
                                  |-> port_hit[1:0] > last_pt_q)
      else $error("port order broken"); // see RULE4
   init_only_a: assert property (go |-> init_v[ch_q[3:0]])
      else $error("idle channel swept"); // see RULE13
   need_only_a: assert property (go |=> meas_req_q && need_q[meas_port_q])
      else $error("unneeded port swept"); // see RULE3
   cal_defer_a: assert property (upd_q != 4'h0 |->
                 ((upd_q & 4'(cal_q)) == 4'h0 ||
                  (upd_q & 4'(cal_q)) == 4'(cal_q)))
      else $error("calibrated trace refreshed early"); // see RULE5
   int_trig_a: assert property (src_q == tss_pkg::SRC_INT &&
                 st_q == S_IDLE && !restart |=> trig_q && st_q == S_CHAN)
      else $error("internal trigger missing"); // see RULE7
   man_trig_a: assert property (src_q == tss_pkg::SRC_MAN && key_rise &&
                 st_q == S_IDLE && !restart |=> trig_q)
      else $error("key trigger missing"); // see RULE10
   bus_trig_a: assert property (src_q == tss_pkg::SRC_BUS && bus_trg &&
                 st_q == S_IDLE && !restart |=> trig_q)
      else $error("bus trigger missing"); // see RULE11
   busy_ign_a: assert property (st_q != S_IDLE |=> !trig_q)
      else $error("trigger taken while busy"); // see RULE19
   sweep_abort_a: assert property (restart |=> !meas_req_q [*2])
      else $error("restart did not abort"); // see RULE18
   hold_all_a: assert property (hold_all && !wr_mode |=> mode_q == '0)
      else $error("hold all failed"); // see RULE16
endmodule : tss_trigger_sweep
`default_nettype wire

// ### dv/tss_far_model.sv
// Far side: trigger terminal, operator key and measurement engine.
// Assumes the bench pulses ext_req or key_req for one clock cycle.
`default_nettype none
module tss_far_model (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       ext_req,
   input  wire logic       key_req,
   input  wire logic [4:0] lat,
   input  wire logic       meas_req_q,
   output var  logic       ext_trig,
   output var  logic       trig_key,
   output var  logic       meas_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ext_q;
   logic [1:0] key_q;
   logic [4:0] cnt_q;
   logic       sent_q;
   // ==========================================================
   // Trigger inputs: held three cycles so the edge is clean
   always_ff @(posedge sys_clk)
      if (sys_rst) ext_q <= 2'h0;
      else if (ext_req) ext_q <= 2'h3;
      else if (ext_q != 2'h0) ext_q <= ext_q - 2'h1;
   always_ff @(posedge sys_clk)
      if (sys_rst) key_q <= 2'h0;
      else if (key_req) key_q <= 2'h3;
      else if (key_q != 2'h0) key_q <= key_q - 2'h1;
   assign ext_trig = (ext_q != 2'h0);
   assign trig_key = (key_q != 2'h0);
   // ==========================================================
   // Engine: one done pulse per request, after lat cycles
   always_ff @(posedge sys_clk)
      if (sys_rst || !meas_req_q)
      begin
         cnt_q     <= 5'h00;
         sent_q    <= 1'b0;
         meas_done <= 1'b0;
      end
      else
      begin
         meas_done <= !sent_q && cnt_q == lat;
         sent_q    <= sent_q | (cnt_q == lat);
         cnt_q     <= cnt_q + 5'h01;
      end
endmodule : tss_far_model
`default_nettype wire

// ### dv/test_trigger_sweep_sequencer.sv
// Bench: AXI4-Lite register tasks and sweep-order checks.
// Assumes the far-side model answers each measurement request.
`default_nettype none
module test_trigger_sweep_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, sys_rst = 1'b1, ext_req = 1'b0, key_req = 1'b0;
   logic [4:0] lat = 5'h02;
   logic ext_trig, trig_key, meas_done, meas_req_q, trig_q;
   logic [3:0] meas_chan_q, upd_q;
   logic [1:0] meas_port_q, s_axi_bresp, s_axi_rresp;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, hist, uh;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   int fail_count = 0, n_checks = 0, n_trig = 0, n_meas = 0, cyc = 0;
   always #25 sys_clk = ~sys_clk;
   tss_trigger_sweep u_dut (.sys_clk, .sys_rst, .ext_trig, .trig_key,
      .meas_done, .meas_req_q, .meas_chan_q, .meas_port_q, .upd_q,
      .trig_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   tss_far_model u_far (.sys_clk, .sys_rst, .ext_req, .key_req, .lat,
      .meas_req_q, .ext_trig, .trig_key, .meas_done);
   // ==========================================================
   // Monitor: measurement order, refresh pulses, hang limit
   always @(posedge sys_clk)
   begin
      if (meas_done && meas_req_q)
      begin
         hist = {hist[25:0], meas_chan_q, meas_port_q};
         n_meas++;
      end
      if (upd_q != 4'h0) uh = {uh[27:0], upd_q};
      if (trig_q) n_trig++;
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         summarize();
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF, input logic [1:0] er = 0);
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd
   task automatic rc(input string nm, input logic [7:0] a,
                     input logic [31:0] e, input logic [1:0] er = 0);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(nm, e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask : rc
   // Busy may lag the trigger, so let it land before polling
   task automatic idle();
      logic [31:0] d;
      logic [1:0]  r;
      repeat (4) @(posedge sys_clk);
      do
      begin
         rd(tss_pkg::OFS_STATUS, d, r);
      end
      while (d[tss_pkg::ST_BUSY] !== 1'b0);
   endtask : idle
   task automatic clr();
      hist = 32'h0;
      uh = 32'h0;
      n_meas = 0;
      n_trig = 0;
   endtask : clr
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rc("disp", tss_pkg::OFS_DISP, tss_pkg::RST_DISP);
      rc("mode", tss_pkg::OFS_MODE, tss_pkg::RST_MODE);
      rc("ports", tss_pkg::OFS_PORTS, {28'h0, tss_pkg::RST_NEED});
      rc("hole", 8'h20, 32'h0, tss_pkg::RESP_ERR);
      wr(8'h24, 32'h1, 4'hF, tss_pkg::RESP_ERR);
      chk("int_start", 32'h1, {31'h0, n_trig > 3});
      // Internal source keeps a continuous channel sweeping
      wr(tss_pkg::OFS_MODE, 32'h2);
      clr();
      repeat (200) @(posedge sys_clk);
      chk("int_runs", 32'h1, {31'h0, n_meas >= 4});
      wr(tss_pkg::OFS_CTRL, 32'h3);
      idle();
      // Order: ch0 cont, ch2 single undisplayed, ch5 hold; ports 1, 3
      wr(tss_pkg::OFS_PORTS, 32'h5);
      wr(tss_pkg::OFS_MODE, 32'h12);
      lat <= 5'h08;
      clr();
      wr(tss_pkg::OFS_CMD, 32'h1);
      wr(tss_pkg::OFS_CMD, 32'h1);
      ext_req <= 1'b1;
      @(posedge sys_clk);
      ext_req <= 1'b0;
      idle();
      chk("order", 32'h0000_220A, hist[23:0]);
      chk("upd", 32'h1414, uh[15:0]);
      chk("trigs", 32'h1, 32'(n_trig));
      rc("mode", tss_pkg::OFS_MODE, 32'h2);
      rc("status", tss_pkg::OFS_STATUS, 32'h0001_0220);
      // External then manual source, each one trigger
      wr(tss_pkg::OFS_CTRL, 32'h1);
      clr();
      ext_req <= 1'b1;
      @(posedge sys_clk);
      ext_req <= 1'b0;
      idle();
      chk("ext", 32'h1, 32'(n_trig));
      chk("ext_meas", 32'h2, 32'(n_meas));
      wr(tss_pkg::OFS_CTRL, 32'h2);
      clr();
      ext_req <= 1'b1;
      @(posedge sys_clk);
      ext_req <= 1'b0;
      key_req <= 1'b1;
      @(posedge sys_clk);
      key_req <= 1'b0;
      idle();
      chk("key", 32'h1, 32'(n_trig));
      // Calibrated ports 1 and 4 refresh together
      wr(tss_pkg::OFS_CTRL, 32'h3);
      wr(tss_pkg::OFS_PORTS, 32'h99);
      clr();
      wr(tss_pkg::OFS_CMD, 32'h1);
      idle();
      chk("cal_upd", 32'h9, uh[15:0]);
      // Restart in mid-measurement
      lat <= 5'h14;
      clr();
      wr(tss_pkg::OFS_CMD, 32'h1);
      wr(tss_pkg::OFS_CMD, 32'h2);
      repeat (2) @(posedge sys_clk);
      chk("abort", 32'h0, {31'h0, meas_req_q});
      chk("abort_n", 32'h0, 32'(n_meas));
      // Group commands; low lane cleared must not act
      wr(tss_pkg::OFS_DISP, 32'h5);
      wr(tss_pkg::OFS_MODE, 32'h6);
      wr(tss_pkg::OFS_CMD, 32'h8);
      rc("cont_disp", tss_pkg::OFS_MODE, 32'h26);
      wr(tss_pkg::OFS_CMD, 32'h4, 4'hE);
      rc("no_lane", tss_pkg::OFS_MODE, 32'h26);
      wr(tss_pkg::OFS_CMD, 32'h4);
      rc("hold_all", tss_pkg::OFS_MODE, 32'h0);
      summarize();
   end
endmodule : test_trigger_sweep_sequencer
`default_nettype wire
